// ---- logic/flic_pkg.sv ----
// package for the four level interrupt controller: register map, fields, vectors
package flic_pkg;

  localparam int          NUM_SRC       = 8;
  localparam int          NUM_LVL       = 4;
  localparam int          ADDR_W        = 10;

  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_EN_MAIN   = 8'hA8;
  localparam logic [7:0]  IDX_EN_SECOND = 8'hB1;
  localparam logic [7:0]  IDX_PRIO_LOW  = 8'hB8;
  localparam logic [7:0]  IDX_PRIO_HIGH = 8'hB7;
  localparam logic [7:0]  IDX_KPD_LOW   = 8'hB2;
  localparam logic [7:0]  IDX_KPD_HIGH  = 8'hB3;
  localparam logic [7:0]  IDX_STATUS    = 8'hB4;

  localparam logic [7:0]  EN_MAIN_RST   = 8'h00;
  localparam logic [7:0]  PRIO_RST      = 8'h00;
  localparam logic [6:0]  PRIO_MASK     = 7'h7F;
  localparam int          GLOBAL_EN_BIT = 7;
  localparam int          TIMER2_BIT    = 5;

  // source index equals polling order, first is polled first
  localparam logic [2:0]  SRC_LINE_ZERO = 3'h0;
  localparam logic [2:0]  SRC_TIMER0    = 3'h1;
  localparam logic [2:0]  SRC_LINE_ONE  = 3'h2;
  localparam logic [2:0]  SRC_TIMER1    = 3'h3;
  localparam logic [2:0]  SRC_SERIAL    = 3'h4;
  localparam logic [2:0]  SRC_TIMER2    = 3'h5;
  localparam logic [2:0]  SRC_COUNTER   = 3'h6;
  localparam logic [2:0]  SRC_KEYPAD    = 3'h7;

  localparam logic [15:0] VEC_COUNTER   = 16'h0033;
  localparam logic [15:0] VEC_KEYPAD    = 16'h004B;

  typedef struct packed {
    logic        valid;
    logic [2:0]  src;
    logic [1:0]  level;
    logic [15:0] vector;
  } flic_req_s;

endpackage

// ---- logic/flic_top.sv ----
// four level interrupt controller with apb register slave
`timescale 1ns/100ps
module flic_top
  import flic_pkg::*;
#(
  parameter logic [15:0] VEC_BASE = 16'h0003,
  parameter logic [15:0] VEC_STEP = 16'h0008
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              irq_line_zero,
  input  wire logic              irq_line_one,
  input  wire logic [5:0]        periph_req,
  output flic_req_s              irq_out,
  input  wire logic              irq_ack,
  input  wire logic              irq_return
);

  logic [7:0]         irq_enable_main_reg;
  logic               keypad_irq_enable_reg;
  logic [6:0]         prio_low_reg;
  logic [6:0]         prio_high_reg;
  logic               kpd_low_reg;
  logic               kpd_high_reg;
  logic [NUM_LVL-1:0] active_reg;
  logic [1:0]         line_sync0_reg;
  logic [1:0]         line_sync1_reg;
  logic [31:0]        rdata_reg;
  flic_req_s          out_reg;

  logic [NUM_SRC-1:0] pending;
  logic [NUM_SRC-1:0] en_vec;
  logic [NUM_SRC-1:0] elig;
  logic [NUM_SRC-1:0] hi_bits;
  logic [NUM_SRC-1:0] lo_bits;
  logic [1:0]         src_lvl [NUM_SRC];
  logic [15:0]        src_vec [NUM_SRC];
  logic               floor_any;
  logic [1:0]         floor_lvl;
  flic_req_s          cand;
  logic [1:0]         elig_max;
  logic [NUM_SRC-1:0] elig_lvl   [NUM_LVL];
  logic [NUM_SRC-1:0] elig_lvl_q [NUM_LVL];
  logic [1:0]         act_top;

  logic               setup;
  logic               acc;
  logic [7:0]         idx;
  logic               mapped;
  logic               global_irq_enable;

  // external lines come from pins: two flops before any use
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      line_sync0_reg <= 2'h0;
      line_sync1_reg <= 2'h0;
    end else begin
      line_sync0_reg <= {irq_line_one, irq_line_zero};
      line_sync1_reg <= line_sync0_reg;
    end
  end

  // peripheral flags are levels held until their owner clears them
  assign pending = {periph_req[5:1], line_sync1_reg[1], periph_req[0],
                    line_sync1_reg[0]};

  assign global_irq_enable = irq_enable_main_reg[GLOBAL_EN_BIT];
  assign en_vec  = {keypad_irq_enable_reg, irq_enable_main_reg[6:0]};
  assign hi_bits = {kpd_high_reg, prio_high_reg};
  assign lo_bits = {kpd_low_reg, prio_low_reg};

  // highest level in service; nothing below or at it may be taken
  always_comb begin
    floor_any = |active_reg;
    floor_lvl = 2'h0;
    for (int l = 0; l < NUM_LVL; l++) begin
      if (active_reg[l]) begin
        floor_lvl = 2'(l);
      end
    end
  end
  assign act_top = floor_lvl;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      assign src_lvl[g] = {hi_bits[g], lo_bits[g]};
      assign elig[g] = pending[g] && en_vec[g] && global_irq_enable &&
                       (!floor_any || (src_lvl[g] > floor_lvl));
      if (g == int'(SRC_COUNTER)) begin : g_pca
        assign src_vec[g] = VEC_COUNTER;
      end else if (g == int'(SRC_KEYPAD)) begin : g_kpd
        assign src_vec[g] = VEC_KEYPAD;
      end else begin : g_std
        assign src_vec[g] = 16'(VEC_BASE + VEC_STEP * 16'(g));
      end
    end
  endgenerate

  // level first, then polling order; strict > keeps the first polled source
  always_comb begin
    cand = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (elig[i] && (!cand.valid || (src_lvl[i] > cand.level))) begin
        cand.valid  = 1'b1;
        cand.src    = 3'(i);
        cand.level  = src_lvl[i];
        cand.vector = src_vec[i];
      end
    end
  end

  // helpers for the checks below
  always_comb begin
    elig_max = 2'h0;
    elig_lvl = '{default: '0};
    for (int i = 0; i < NUM_SRC; i++) begin
      if (elig[i] && (src_lvl[i] > elig_max)) begin
        elig_max = src_lvl[i];
      end
      if (elig[i]) begin
        elig_lvl[src_lvl[i]][i] = 1'b1;
      end
    end
  end

  // eligible sources per level, one cycle old so they line up with irq_out
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      elig_lvl_q <= '{default: '0};
    end else begin
      elig_lvl_q <= elig_lvl;
    end
  end

  // request toward the core; dropped the cycle after an accept
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      out_reg <= '0;
    end else begin
      out_reg       <= cand;
      out_reg.valid <= cand.valid && !(irq_ack && out_reg.valid);
    end
  end
  assign irq_out = out_reg;

  // in-service levels: set on accept, top one cleared on return
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      active_reg <= '0;
    end else begin
      if (irq_return && floor_any) begin
        active_reg[act_top] <= 1'b0;
      end
      if (irq_ack && out_reg.valid) begin
        active_reg[out_reg.level] <= 1'b1;
      end
    end
  end

  // apb slave, zero wait states
  assign setup   = psel && !penable;
  assign acc     = psel && penable;
  assign idx     = paddr[ADDR_W-1:2];
  assign mapped  = (paddr[1:0] == 2'h0) &&
                   (idx == IDX_EN_MAIN  || idx == IDX_EN_SECOND || idx == IDX_PRIO_LOW ||
                    idx == IDX_PRIO_HIGH || idx == IDX_KPD_LOW  || idx == IDX_KPD_HIGH ||
                    idx == IDX_STATUS);
  assign pready  = acc;
  assign pslverr = acc && !mapped;
  assign prdata  = rdata_reg;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_reg <= 32'h0;
    end else if (setup && !mapped) begin
      rdata_reg <= 32'h0;
    end else if (setup) begin
      unique case (idx)
        IDX_EN_MAIN:   rdata_reg <= {24'h0, irq_enable_main_reg};
        IDX_EN_SECOND: rdata_reg <= {31'h0, keypad_irq_enable_reg};
        IDX_PRIO_LOW:  rdata_reg <= {25'h0, prio_low_reg};
        IDX_PRIO_HIGH: rdata_reg <= {25'h0, prio_high_reg};
        IDX_KPD_LOW:   rdata_reg <= {31'h0, kpd_low_reg};
        IDX_KPD_HIGH:  rdata_reg <= {31'h0, kpd_high_reg};
        IDX_STATUS:    rdata_reg <= {24'h0, out_reg.valid, out_reg.src, active_reg};
        default:       rdata_reg <= 32'h0;
      endcase
    end
  end

  // reserved bit 7 of the priority registers is not stored
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq_enable_main_reg   <= EN_MAIN_RST;
      keypad_irq_enable_reg <= 1'b0;
      prio_low_reg          <= PRIO_RST[6:0];
      prio_high_reg         <= PRIO_RST[6:0];
      kpd_low_reg           <= 1'b0;
      kpd_high_reg          <= 1'b0;
    end else if (acc && pwrite && mapped) begin
      unique case (idx)
        IDX_EN_MAIN:   irq_enable_main_reg   <= pwdata[7:0];
        IDX_EN_SECOND: keypad_irq_enable_reg <= pwdata[0];
        IDX_PRIO_LOW:  prio_low_reg          <= pwdata[6:0] & PRIO_MASK;
        IDX_PRIO_HIGH: prio_high_reg         <= pwdata[6:0] & PRIO_MASK;
        IDX_KPD_LOW:   kpd_low_reg           <= pwdata[0];
        IDX_KPD_HIGH:  kpd_high_reg          <= pwdata[0];
        default:       ;
      endcase
    end
  end

  // checks; irq_out is a flop, so its causes are looked up one cycle back
  global_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !global_irq_enable |=> !irq_out.valid)
    else $error("request raised while global enable clear");

  enable_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    irq_out.valid |-> |($past(en_vec) & (8'h01 << irq_out.src)) && $past(global_irq_enable))
    else $error("request raised from disabled source");

  pend_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    irq_out.valid |-> |($past(pending) & (8'h01 << irq_out.src)))
    else $error("request raised from idle source");

  timer2_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !irq_enable_main_reg[TIMER2_BIT] |=> !(irq_out.valid && irq_out.src == SRC_TIMER2))
    else $error("timer 2 request passed while disabled");

  keypad_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !keypad_irq_enable_reg |=> !(irq_out.valid && irq_out.src == SRC_KEYPAD))
    else $error("keypad request passed while disabled");

  counter_vector_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    irq_out.valid && irq_out.src == SRC_COUNTER |-> irq_out.vector == VEC_COUNTER)
    else $error("counter array vector wrong");

  kpd_vector_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    irq_out.valid && irq_out.src == SRC_KEYPAD |-> irq_out.vector == VEC_KEYPAD)
    else $error("keypad vector wrong");

  std_vector_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    irq_out.valid && irq_out.src < SRC_COUNTER |-> irq_out.vector == 16'(VEC_BASE + VEC_STEP * 16'(irq_out.src)))
    else $error("standard vector wrong");

  // the pins reach arbitration two edges late, never sooner
  line_sync_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $past(resetn) && $past(resetn, 2) |->
      pending[SRC_LINE_ZERO] == $past(irq_line_zero, 2) && pending[SRC_LINE_ONE] == $past(irq_line_one, 2))
    else $error("external line not two edges late");

  level_map_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    irq_out.valid |->
      irq_out.level == {|($past(hi_bits) & (8'h01 << irq_out.src)), |($past(lo_bits) & (8'h01 << irq_out.src))})
    else $error("level does not follow priority bits");

  nest_only_up_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    irq_out.valid && $past(floor_any) |-> irq_out.level > $past(act_top))
    else $error("request not above running level");

  top_level_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    active_reg[3] && !irq_return |=> !irq_out.valid)
    else $error("highest level routine preempted");

  level_first_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    irq_out.valid |-> irq_out.level == $past(elig_max))
    else $error("lower level served before higher");

  poll_order_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    irq_out.valid |->
      (elig_lvl_q[irq_out.level] & ((8'h01 << irq_out.src) - 8'h01)) == 8'h00)
    else $error("polling order not kept");

  accept_mark_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    irq_ack && irq_out.valid && !irq_return |=> active_reg[$past(irq_out.level)] ##0 !irq_out.valid)
    else $error("accept not recorded");

  return_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    irq_return && !(irq_ack && irq_out.valid) && floor_any |=> !active_reg[$past(act_top)])
    else $error("return did not end top routine");

  en_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    acc && pwrite && mapped && idx == IDX_EN_MAIN |=> irq_enable_main_reg == $past(pwdata[7:0]))
    else $error("main enable write lost");

  kpd_en_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    acc && pwrite && mapped && idx == IDX_EN_SECOND |=> keypad_irq_enable_reg == $past(pwdata[0]))
    else $error("keypad enable write lost");

  prio_low_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    acc && pwrite && mapped && idx == IDX_PRIO_LOW |=> prio_low_reg == $past(pwdata[6:0]))
    else $error("low priority write lost");

  prio_high_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    acc && pwrite && mapped && idx == IDX_PRIO_HIGH |=> prio_high_reg == $past(pwdata[6:0]))
    else $error("high priority write lost");

  kpd_low_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    acc && pwrite && mapped && idx == IDX_KPD_LOW |=> kpd_low_reg == $past(pwdata[0]))
    else $error("keypad low priority write lost");

  kpd_high_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    acc && pwrite && mapped && idx == IDX_KPD_HIGH |=> kpd_high_reg == $past(pwdata[0]))
    else $error("keypad high priority write lost");

  refused_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    acc && pwrite && !mapped |=>
      $stable(irq_enable_main_reg) && $stable(prio_low_reg) && $stable(prio_high_reg) && $stable(keypad_irq_enable_reg))
    else $error("refused write changed a register");

  refused_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    setup && !mapped |=> prdata == 32'h0)
    else $error("refused read returned data");

  reset_value_a: assert property (@(posedge sys_clk)
    $rose(resetn) |-> irq_enable_main_reg == EN_MAIN_RST && prio_low_reg == 7'h00 && prio_high_reg == 7'h00 &&
      !keypad_irq_enable_reg)
    else $error("registers not cleared by reset");

endmodule

// ---- dv/flic_core_model.sv ----
// core side model: takes offered vectors, returns from routines on command
`timescale 1ns/100ps
module flic_core_model
  import flic_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      resetn,
  input  wire flic_req_s irq_out,
  input  wire logic      ack_on,
  input  wire logic      ret_req,
  output logic           irq_ack,
  output logic           irq_return,
  output flic_req_s      taken
);
  // ack one cycle after valid is seen, as a core sampling at an edge would
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq_ack <= 1'b0;
      taken   <= '0;
    end else if (irq_ack) begin
      irq_ack <= 1'b0;
      if (irq_out.valid) taken <= irq_out;
    end else if (ack_on && irq_out.valid) begin
      irq_ack <= 1'b1;
    end
  end
  // return follows the command one cycle later and lasts as many cycles as the command is held
  always_ff @(posedge sys_clk) begin
    irq_return <= resetn & ret_req;
  end
endmodule

// ---- dv/flic_top_tb.sv ----
// self-checking bench for the four level interrupt controller
`timescale 1ns/100ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module flic_top_tb
  import flic_pkg::*;
;
  localparam logic [15:0] VB = 16'h0003;
  localparam logic [15:0] VS = 16'h0008;
  logic              sys_clk, resetn, psel, penable, pwrite, pready, pslverr, e;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, v;
  logic [7:0]        reqs;
  logic              ack_on, ret_req, irq_ack, irq_return;
  flic_req_s         irq_out, taken;
  int                fails, n_compared;

  flic_top #(.VEC_BASE(VB), .VEC_STEP(VS)) i_flic_top (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_line_zero(reqs[0]), .irq_line_one(reqs[2]),
    .periph_req({reqs[7], reqs[6], reqs[5], reqs[4], reqs[3], reqs[1]}),
    .irq_out(irq_out), .irq_ack(irq_ack), .irq_return(irq_return));

  flic_core_model i_flic_core_model (
    .sys_clk(sys_clk), .resetn(resetn), .irq_out(irq_out), .ack_on(ack_on),
    .ret_req(ret_req), .irq_ack(irq_ack), .irq_return(irq_return), .taken(taken));

  task automatic complete_run();
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // request held until pready is seen high at an edge; one idle cycle after
  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {idx, 2'b00}, {24'h0, d}, v, e);
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, {idx, 2'b00}, 32'h0, v, e);
    `CHK({e, v}, {1'b0, exp})
  endtask

  function automatic logic [15:0] vec(input int s);
    return (s == 6) ? 16'h0033 : (s == 7) ? 16'h004B : VB + VS * s[15:0];
  endfunction

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    complete_run();
  end

  initial begin
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    reqs = '0; ack_on = 1'b0; ret_req = 1'b0; fails = 0; n_compared = 0;
    tick(4);
    resetn <= 1'b1;
    tick(1);
    rchk(IDX_EN_MAIN, 32'h0);
    rchk(IDX_PRIO_LOW, 32'h0);
    rchk(IDX_PRIO_HIGH, 32'h0);
    rchk(IDX_EN_SECOND, 32'h0);
    wr(IDX_EN_MAIN, 8'hA5);
    rchk(IDX_EN_MAIN, 32'hA5);
    wr(IDX_PRIO_HIGH, 8'hFF);
    rchk(IDX_PRIO_HIGH, 32'h7F);
    wr(IDX_PRIO_LOW, 8'hFF);
    rchk(IDX_PRIO_LOW, 32'h7F);
    // misaligned write and unmapped read are refused without side effects
    apb(1'b1, 10'h2A1, 32'hFF, v, e);
    `CHK(e, 1'b1)
    apb(1'b0, 10'h2A1, 32'h0, v, e);
    `CHK({e, v}, 33'h100000000)
    apb(1'b0, 10'h000, 32'h0, v, e);
    `CHK({e, v}, 33'h100000000)
    rchk(IDX_EN_MAIN, 32'hA5);
    wr(IDX_PRIO_HIGH, 8'h00);
    wr(IDX_PRIO_LOW, 8'h00);
    wr(IDX_EN_MAIN, 8'h7F);
    wr(IDX_EN_SECOND, 8'h01);
    reqs <= 8'hFF;
    tick(5);
    `CHK(irq_out.valid, 1'b0)
    wr(IDX_EN_MAIN, 8'hFF);
    tick(3);
    `CHK(irq_out.src, SRC_LINE_ZERO)
    for (int l = 0; l < 4; l++) begin
      wr(IDX_PRIO_LOW, {4'h0, l[0], 3'h0});
      wr(IDX_PRIO_HIGH, {4'h0, l[1], 3'h0});
      tick(3);
      `CHK(irq_out.level, l[1:0])
      `CHK(irq_out.src, (l == 0) ? SRC_LINE_ZERO : SRC_TIMER1)
    end
    wr(IDX_PRIO_LOW, 8'h00);
    wr(IDX_PRIO_HIGH, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(IDX_EN_MAIN, 8'h80);
      wr(IDX_EN_SECOND, 8'h00);
      reqs <= 8'h01 << s;
      tick(5);
      `CHK(irq_out.valid, 1'b0)
      if (s < 7) wr(IDX_EN_MAIN, 8'h80 | (8'h01 << s));
      else wr(IDX_EN_SECOND, 8'h01);
      tick(3);
      `CHK({irq_out.valid, irq_out.src, irq_out.vector}, {1'b1, s[2:0], vec(s)})
    end
    // nesting: timer1 and serial at level 1, timer2 and counter at level 3
    reqs <= 8'h00;
    wr(IDX_EN_MAIN, 8'hFF);
    wr(IDX_EN_SECOND, 8'h00);
    wr(IDX_PRIO_LOW, 8'h78);
    wr(IDX_PRIO_HIGH, 8'h60);
    ack_on <= 1'b1;
    reqs <= 8'h08;
    tick(5);
    `CHK(taken.src, SRC_TIMER1)
    reqs <= 8'h18;
    tick(5);
    `CHK({irq_out.valid, taken.src}, {1'b0, SRC_TIMER1})
    reqs <= 8'h58;
    tick(5);
    `CHK(taken.src, SRC_COUNTER)
    apb(1'b0, {IDX_STATUS, 2'b00}, 32'h0, v, e);
    `CHK(v[3:0], 4'hA)
    reqs <= 8'h78;
    tick(5);
    `CHK({irq_out.valid, taken.src}, {1'b0, SRC_COUNTER})
    ret_req <= 1'b1;
    tick(1);
    ret_req <= 1'b0;
    tick(5);
    `CHK({taken.src, taken.level}, {SRC_TIMER2, 2'h3})
    complete_run();
  end
endmodule
